// [src/mstr_apb_slave.sv]
`timescale 1ns/1ps
module mstr_apb_slave
   import mstr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // APB
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [APB_AW-1:0] paddr_i,
   output logic pready_o,
   output logic [APB_DW-1:0] prdata_o,
   output logic pslverr_o,
   // Register file side
   output logic [IDX_W-1:0] reg_idx_o,
   output logic aligned_o,
   input wire logic reg_hit_i,
   input wire logic [REG_W-1:0] rd_value_i,
   output logic commit_o,
   output logic commit_wr_o
);

   typedef struct packed {
      mstr_apb_st_t fsm;
      logic [APB_DW-1:0] rdata;
      logic err;
   } mstr_apb_q_t;

   mstr_apb_q_t q;
   mstr_apb_q_t next_q;

   assign reg_idx_o = paddr_i[IDX_W+1:2];
   assign aligned_o = (paddr_i[1:0] == 2'h0);

   always_comb begin
      next_q = q;
      case (q.fsm)
         MSTR_IDLE: begin
            // Read value captured one cycle before the answer
            if (psel_i && penable_i) begin
               next_q.err = !reg_hit_i;
               next_q.rdata = (reg_hit_i && !pwrite_i) ? {16'h0000, rd_value_i} : 32'h00000000;
               next_q.fsm = MSTR_ACK;
            end
         end
         MSTR_ACK: begin
            next_q.fsm = MSTR_IDLE;
         end
         default: begin
            next_q.fsm = MSTR_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{fsm: MSTR_IDLE, rdata: 32'h00000000, err: 1'b0};
      end else begin
         q <= next_q;
      end
   end

   assign pready_o = (q.fsm == MSTR_ACK);
   assign pslverr_o = (q.fsm == MSTR_ACK) && q.err;
   assign prdata_o = q.rdata;
   assign commit_o = (q.fsm == MSTR_ACK) && psel_i && penable_i && !q.err;
   assign commit_wr_o = pwrite_i;

endmodule

// [src/mstr_pkg.sv]
package mstr_pkg;

   // APB side
   localparam int APB_AW = 16;
   localparam int APB_DW = 32;
   localparam int REG_W = 16;
   localparam int IDX_W = 12;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_OVF_FLAGS = 12'h802;
   localparam logic [IDX_W-1:0] IDX_OVF_MASK = 12'h804;
   localparam logic [IDX_W-1:0] IDX_TONE_SETUP = 12'h810;
   localparam logic [IDX_W-1:0] IDX_REC1_REGION = 12'h820;
   localparam logic [IDX_W-1:0] IDX_REC1_CONS = 12'h822;
   localparam logic [IDX_W-1:0] IDX_REC1_PROD = 12'h824;
   localparam logic [IDX_W-1:0] IDX_REC2_REGION = 12'h828;

   // Overflow flag positions
   localparam int OVF_N = 3;
   localparam int OVF_CELL = 0;
   localparam int OVF_REC1 = 1;
   localparam int OVF_REC2 = 2;

   // Tone setup fields
   localparam int TONE_BASE_LSB = 0;
   localparam int TONE_BASE_W = 5;
   localparam int TONE_SIZE_LSB = 5;
   localparam int TONE_SIZE_W = 2;
   localparam int TONE_SDRAM_EN = 7;
   localparam int TONE_SSRAM_EN = 8;
   localparam int TONE_W = 9;
   localparam int TONE_ADDR_W = 24;
   localparam int TONE_ADDR_LSB = 19;
   localparam int TONE_MIN_LOG2 = 14;
   localparam logic [1:0] TONE_SIZE_RSVD = 2'h3;
   localparam logic [1:0] TONE_SIZE_MAX = 2'h2;

   // Recovery region fields
   localparam int REG_BASE_LSB = 0;
   localparam int REG_BASE_W = 9;
   localparam int REG_SIZE_LSB = 9;
   localparam int REG_SIZE_W = 3;
   localparam int REGION_W = 12;
   localparam int REC_ADDR_W = 21;
   localparam int REC_ADDR_LSB = 12;
   localparam int REC_MIN_LOG2 = 12;
   localparam logic [2:0] REC_SIZE_MAX = 3'h5;

   // Ring pointers
   localparam int PTR_W = 14;
   localparam int POINT_LOG2 = 4;
   localparam int RING_MIN_POINTS = (1 << REC_MIN_LOG2) >> POINT_LOG2;

   localparam logic [REG_W-1:0] RST_VAL = 16'h0000;

   typedef enum logic [1:0] {
      MSTR_IDLE = 2'b01,
      MSTR_ACK = 2'b10
   } mstr_apb_st_t;

endpackage

// [src/mstr_regs.sv]
`timescale 1ns/1ps
module mstr_regs
   import mstr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // APB
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [APB_AW-1:0] paddr_i,
   input wire logic [APB_DW-1:0] pwdata_i,
   output logic pready_o,
   output logic [APB_DW-1:0] prdata_o,
   output logic pslverr_o,
   // Overflow events
   input wire logic cell_evt_ovf_i,
   input wire logic rec2_ovf_i,
   output logic irq_o,
   // Tone store
   output logic [TONE_ADDR_W-1:0] tone_base_addr_o,
   output logic [TONE_SIZE_W-1:0] tone_size_log2_o,
   output logic sdram_tone_en_o,
   output logic ssram_tone_en_o,
   // First recovery ring
   input wire logic rec1_store_i,
   output logic [REC_ADDR_W-1:0] rec1_base_addr_o,
   output logic [REG_SIZE_W-1:0] rec1_size_log2_o,
   output logic [PTR_W-1:0] rec1_store_idx_o,
   output logic [PTR_W-1:0] rec1_prod_ptr_o,
   output logic [PTR_W-1:0] rec1_cons_ptr_o,
   output logic rec1_full_o,
   output logic rec1_empty_o,
   // Second recovery ring
   output logic [REC_ADDR_W-1:0] rec2_base_addr_o,
   output logic [REG_SIZE_W-1:0] rec2_size_log2_o
);

   typedef struct packed {
      logic [OVF_N-1:0] flags;
      logic [OVF_N-1:0] mask;
      logic [TONE_W-1:0] tone;
      logic [REGION_W-1:0] region1;
      logic [PTR_W-1:0] cons1;
      logic [REGION_W-1:0] region2;
   } mstr_regs_q_t;

   mstr_regs_q_t q;
   mstr_regs_q_t next_q;

   logic [IDX_W-1:0] reg_idx;
   logic aligned;
   logic reg_hit;
   logic [REG_W-1:0] rd_value;
   logic commit;
   logic commit_wr;
   logic [REG_W-1:0] wdata;
   logic [PTR_W-1:0] prod1;
   logic rec1_ovf;
   logic [OVF_N-1:0] ovf_evt;
   logic [OVF_N-1:0] ovf_clr;
   logic flags_read;
   logic [TONE_SIZE_W-1:0] tone_code;

   assign wdata = pwdata_i[REG_W-1:0];

   mstr_apb_slave u_apb (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .psel_i(psel_i),
      .penable_i(penable_i),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .pready_o(pready_o),
      .prdata_o(prdata_o),
      .pslverr_o(pslverr_o),
      .reg_idx_o(reg_idx),
      .aligned_o(aligned),
      .reg_hit_i(reg_hit),
      .rd_value_i(rd_value),
      .commit_o(commit),
      .commit_wr_o(commit_wr)
   );

   mstr_ring_ptr u_ring1 (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .size_code_i(q.region1[REG_SIZE_LSB +: REG_SIZE_W]),
      .cons_ptr_i(q.cons1),
      .store_i(rec1_store_i),
      .prod_ptr_o(prod1),
      .store_idx_o(rec1_store_idx_o),
      .full_o(rec1_full_o),
      .empty_o(rec1_empty_o),
      .overflow_o(rec1_ovf)
   );

   // Address decode
   always_comb begin
      reg_hit = 1'b0;
      if (aligned && (paddr_i[APB_AW-1:IDX_W+2] == 2'h0)) begin
         case (reg_idx)
            IDX_OVF_FLAGS, IDX_OVF_MASK, IDX_TONE_SETUP, IDX_REC1_REGION,
            IDX_REC1_CONS, IDX_REC1_PROD, IDX_REC2_REGION: begin
               reg_hit = 1'b1;
            end
            default: begin
               reg_hit = 1'b0;
            end
         endcase
      end
   end

   // Read value, upper bits zero-filled
   always_comb begin
      rd_value = RST_VAL;
      case (reg_idx)
         IDX_OVF_FLAGS: begin
            rd_value = {13'h0000, q.flags};
         end
         IDX_OVF_MASK: begin
            rd_value = {13'h0000, q.mask};
         end
         IDX_TONE_SETUP: begin
            rd_value = {7'h00, q.tone};
         end
         IDX_REC1_REGION: begin
            rd_value = {4'h0, q.region1};
         end
         IDX_REC1_CONS: begin
            rd_value = {2'h0, q.cons1};
         end
         IDX_REC1_PROD: begin
            rd_value = {2'h0, prod1};
         end
         IDX_REC2_REGION: begin
            rd_value = {4'h0, q.region2};
         end
         default: begin
            rd_value = RST_VAL;
         end
      endcase
   end

   assign ovf_evt[OVF_CELL] = cell_evt_ovf_i;
   assign ovf_evt[OVF_REC1] = rec1_ovf;
   assign ovf_evt[OVF_REC2] = rec2_ovf_i;

   // Only the bits the host actually saw are cleared
   assign flags_read = commit && !commit_wr && (reg_idx == IDX_OVF_FLAGS);
   assign ovf_clr = flags_read ? prdata_o[OVF_N-1:0] : 3'h0;

   always_comb begin
      next_q = q;
      // Set wins over a clear in the same cycle
      next_q.flags = (q.flags & ~ovf_clr) | ovf_evt;
      if (commit && commit_wr) begin
         case (reg_idx)
            IDX_OVF_MASK: begin
               next_q.mask = wdata[OVF_N-1:0];
            end
            IDX_TONE_SETUP: begin
               // Upper bits are expected zero and not stored
               next_q.tone = wdata[TONE_W-1:0];
            end
            IDX_REC1_REGION: begin
               next_q.region1 = wdata[REGION_W-1:0];
            end
            IDX_REC1_CONS: begin
               next_q.cons1 = wdata[PTR_W-1:0];
            end
            IDX_REC2_REGION: begin
               next_q.region2 = wdata[REGION_W-1:0];
            end
            default: begin
               next_q.mask = q.mask;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign irq_o = |(q.flags & q.mask);

   // Tone store outputs
   // Reserved size code treated as the largest size
   assign tone_code = q.tone[TONE_SIZE_LSB +: TONE_SIZE_W];
   assign tone_size_log2_o = (tone_code == TONE_SIZE_RSVD) ? TONE_SIZE_MAX : tone_code;
   assign tone_base_addr_o = {q.tone[TONE_BASE_LSB +: TONE_BASE_W], 19'h00000};
   assign sdram_tone_en_o = q.tone[TONE_SDRAM_EN];
   assign ssram_tone_en_o = q.tone[TONE_SSRAM_EN];

   // Recovery ring outputs
   assign rec1_base_addr_o = {q.region1[REG_BASE_LSB +: REG_BASE_W], 12'h000};
   assign rec1_size_log2_o = q.region1[REG_SIZE_LSB +: REG_SIZE_W];
   assign rec1_prod_ptr_o = prod1;
   assign rec1_cons_ptr_o = q.cons1;
   assign rec2_base_addr_o = {q.region2[REG_BASE_LSB +: REG_BASE_W], 12'h000};
   assign rec2_size_log2_o = q.region2[REG_SIZE_LSB +: REG_SIZE_W];

   // Assertions

   a_cell_flag_set: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      cell_evt_ovf_i |=> q.flags[OVF_CELL] ##1 (q.flags[OVF_CELL] || $past(flags_read)))
      else $error("cell queue overflow flag not latched");

   a_rec1_flag_set: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (rec1_store_i && rec1_full_o) |=> (q.flags[OVF_REC1] && $stable(prod1)))
      else $error("first ring overflow not flagged");

   a_rec2_flag_set: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      rec2_ovf_i |=> q.flags[OVF_REC2])
      else $error("second ring overflow not flagged");

   a_status_upper_zero: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (pready_o && psel_i && !pwrite_i && (reg_idx == IDX_OVF_FLAGS || reg_idx == IDX_OVF_MASK))
      |-> (prdata_o[REG_W-1:OVF_N] == 13'h0000))
      else $error("reserved flag or mask bits read nonzero");

   a_irq_cause: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (rec2_ovf_i && q.mask[OVF_REC2]) ##1 q.mask[OVF_REC2] |-> irq_o)
      else $error("enabled overflow did not raise interrupt");

   a_irq_quiet: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (q.mask == 3'h0) |-> !irq_o)
      else $error("interrupt raised with all enables off");

   a_tone_map: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (commit && commit_wr && reg_idx == IDX_TONE_SETUP)
      |=> (tone_base_addr_o[TONE_ADDR_W-1:TONE_ADDR_LSB] == $past(wdata[TONE_BASE_W-1:0]))
      && (sdram_tone_en_o == $past(wdata[TONE_SDRAM_EN]))
      && (ssram_tone_en_o == $past(wdata[TONE_SSRAM_EN])))
      else $error("tone setup not applied");

   a_rec1_map: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (commit && commit_wr && reg_idx == IDX_REC1_REGION)
      |=> (rec1_base_addr_o[REC_ADDR_W-1:REC_ADDR_LSB] == $past(wdata[REG_BASE_W-1:0]))
      && (rec1_size_log2_o == $past(wdata[REGION_W-1:REG_SIZE_LSB])))
      else $error("first ring region not applied");

   a_prod_advance: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (rec1_store_i && !rec1_full_o) |=> (prod1 != $past(prod1)))
      else $error("producer pointer did not advance");

   a_prod_upper_zero: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (pready_o && psel_i && !pwrite_i && reg_idx == IDX_REC1_PROD)
      |-> (prdata_o[REG_W-1:PTR_W] == 2'h0))
      else $error("producer pointer reserved bits nonzero");

   a_flag_sticky: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (q.flags[OVF_CELL] && !flags_read) |=> q.flags[OVF_CELL])
      else $error("overflow flag dropped without a read");

   a_full_not_empty: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      !(rec1_full_o && rec1_empty_o))
      else $error("ring reports full and empty together");

   a_tone_size_map: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (commit && commit_wr && reg_idx == IDX_TONE_SETUP
      && wdata[TONE_SIZE_LSB +: TONE_SIZE_W] != TONE_SIZE_RSVD)
      |=> (tone_size_log2_o == $past(wdata[TONE_SIZE_LSB +: TONE_SIZE_W])))
      else $error("tone size code not applied");

   a_tone_en_hold: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      !(commit && commit_wr && reg_idx == IDX_TONE_SETUP)
      |=> ($stable(sdram_tone_en_o) && $stable(ssram_tone_en_o)))
      else $error("tone enable changed without a write");

   a_rec2_map: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (commit && commit_wr && reg_idx == IDX_REC2_REGION)
      |=> (rec2_base_addr_o[REC_ADDR_W-1:REC_ADDR_LSB] == $past(wdata[REG_BASE_W-1:0]))
      && (rec2_size_log2_o == $past(wdata[REGION_W-1:REG_SIZE_LSB])))
      else $error("second ring region not applied");

   a_rec_base_low: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (rec1_base_addr_o[REC_ADDR_LSB-1:0] == 12'h000)
      && (rec2_base_addr_o[REC_ADDR_LSB-1:0] == 12'h000))
      else $error("ring base address low bits nonzero");

   a_tone_base_low: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      tone_base_addr_o[TONE_ADDR_LSB-1:0] == 19'h00000)
      else $error("tone base address low bits nonzero");

   a_cons_write: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (commit && commit_wr && reg_idx == IDX_REC1_CONS)
      |=> (rec1_cons_ptr_o == $past(wdata[PTR_W-1:0])))
      else $error("consumer pointer write not applied");

   a_prod_readback: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (pready_o && !pslverr_o && !pwrite_i && reg_idx == IDX_REC1_PROD)
      |-> (prdata_o[PTR_W-1:0] == $past(prod1)))
      else $error("producer pointer read value wrong");

   a_flag_clear: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (flags_read && prdata_o[OVF_CELL] && !cell_evt_ovf_i) |=> !q.flags[OVF_CELL])
      else $error("cell flag not cleared by read");

   a_rec1_sticky: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (q.flags[OVF_REC1] && !flags_read) |=> q.flags[OVF_REC1])
      else $error("first ring flag dropped without a read");

   a_rec2_sticky: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (q.flags[OVF_REC2] && !flags_read) |=> q.flags[OVF_REC2])
      else $error("second ring flag dropped without a read");

endmodule

// [src/mstr_ring_ptr.sv]
`timescale 1ns/1ps
module mstr_ring_ptr
   import mstr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Ring setup
   input wire logic [REG_SIZE_W-1:0] size_code_i,
   input wire logic [PTR_W-1:0] cons_ptr_i,
   // Point store
   input wire logic store_i,
   output logic [PTR_W-1:0] prod_ptr_o,
   output logic [PTR_W-1:0] store_idx_o,
   output logic full_o,
   output logic empty_o,
   output logic overflow_o
);

   typedef struct packed {
      logic [PTR_W-1:0] wptr;
   } mstr_ring_q_t;

   mstr_ring_q_t q;
   mstr_ring_q_t next_q;
   logic [REG_SIZE_W-1:0] code;
   logic [PTR_W-1:0] points;
   logic [PTR_W-1:0] ptr_mask;
   logic [PTR_W-1:0] fill;

   // Reserved size codes act as the largest ring
   assign code = (size_code_i > REC_SIZE_MAX) ? REC_SIZE_MAX : size_code_i;
   assign points = PTR_W'(RING_MIN_POINTS << code);
   // Pointer spans twice the ring so full differs from empty
   assign ptr_mask = PTR_W'((RING_MIN_POINTS << (code + 3'h1)) - 1);
   assign fill = (q.wptr - cons_ptr_i) & ptr_mask;
   assign full_o = (fill == points);
   assign empty_o = (fill == 14'h0000);

   always_comb begin
      next_q = q;
      if (store_i && !full_o) begin
         next_q.wptr = (q.wptr + 14'h0001) & ptr_mask;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{wptr: 14'h0000};
      end else begin
         q <= next_q;
      end
   end

   assign prod_ptr_o = q.wptr;
   assign store_idx_o = q.wptr & (points - 14'h0001);
   assign overflow_o = store_i && full_o;

endmodule

// [testbench/mstr_regs_tb.sv]
`timescale 1ns/1ps
module mstr_regs_tb;
   import mstr_pkg::*;

   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [APB_AW-1:0] paddr_i = '0;
   logic [APB_DW-1:0] pwdata_i = '0;
   logic cell_evt_ovf_i = 1'b0;
   logic rec2_ovf_i = 1'b0;
   logic rec1_store_i = 1'b0;
   logic pready_o;
   logic [APB_DW-1:0] prdata_o;
   logic pslverr_o;
   logic irq_o;
   logic [TONE_ADDR_W-1:0] tone_base_addr_o;
   logic [TONE_SIZE_W-1:0] tone_size_log2_o;
   logic sdram_tone_en_o;
   logic ssram_tone_en_o;
   logic [REC_ADDR_W-1:0] rec1_base_addr_o;
   logic [REG_SIZE_W-1:0] rec1_size_log2_o;
   logic [PTR_W-1:0] rec1_store_idx_o;
   logic [PTR_W-1:0] rec1_prod_ptr_o;
   logic [PTR_W-1:0] rec1_cons_ptr_o;
   logic rec1_full_o;
   logic rec1_empty_o;
   logic [REC_ADDR_W-1:0] rec2_base_addr_o;
   logic [REG_SIZE_W-1:0] rec2_size_log2_o;
   int fails = 0;
   int compares = 0;
   logic [IDX_W-1:0] idx_tab [7] = '{IDX_OVF_FLAGS, IDX_OVF_MASK, IDX_TONE_SETUP,
      IDX_REC1_REGION, IDX_REC1_CONS, IDX_REC1_PROD, IDX_REC2_REGION};

   mstr_regs DUT (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
      .prdata_o(prdata_o), .pslverr_o(pslverr_o), .cell_evt_ovf_i(cell_evt_ovf_i),
      .rec2_ovf_i(rec2_ovf_i), .irq_o(irq_o), .tone_base_addr_o(tone_base_addr_o),
      .tone_size_log2_o(tone_size_log2_o), .sdram_tone_en_o(sdram_tone_en_o),
      .ssram_tone_en_o(ssram_tone_en_o), .rec1_store_i(rec1_store_i),
      .rec1_base_addr_o(rec1_base_addr_o), .rec1_size_log2_o(rec1_size_log2_o),
      .rec1_store_idx_o(rec1_store_idx_o), .rec1_prod_ptr_o(rec1_prod_ptr_o),
      .rec1_cons_ptr_o(rec1_cons_ptr_o), .rec1_full_o(rec1_full_o),
      .rec1_empty_o(rec1_empty_o), .rec2_base_addr_o(rec2_base_addr_o),
      .rec2_size_log2_o(rec2_size_log2_o)
   );

   always #5 core_clk_i = ~core_clk_i;

   function automatic logic [15:0] ba(input logic [IDX_W-1:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   task automatic print_verdict;
      if (fails == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One APB transfer; the watchdog bounds the wait for pready
   task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= addr;
      pwdata_i <= wd;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge core_clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] addr, input logic [31:0] wd);
      logic [31:0] r;
      logic e;
      apb(1'b1, addr, wd, r, e);
      chk("write pslverr", 32'h0, 32'(e));
   endtask

   task automatic rd(input string name, input logic [15:0] addr, input logic [15:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, addr, 32'h0, r, e);
      chk(name, {16'h0000, exp}, r);
      chk("read pslverr", 32'h0, 32'(e));
   endtask

   task automatic tick;
      @(posedge core_clk_i);
      #1;
   endtask

   task automatic pulse(input logic sel);
      @(posedge core_clk_i);
      if (sel) begin
         rec2_ovf_i <= 1'b1;
      end else begin
         cell_evt_ovf_i <= 1'b1;
      end
      @(posedge core_clk_i);
      rec2_ovf_i <= 1'b0;
      cell_evt_ovf_i <= 1'b0;
   endtask

   task automatic t_reset;
      tick;
      chk("irq", 32'h0, 32'(irq_o));
      chk("empty", 32'h1, 32'(rec1_empty_o));
      chk("full", 32'h0, 32'(rec1_full_o));
      foreach (idx_tab[i]) rd("reset value", ba(idx_tab[i]), 16'h0000);
   endtask

   task automatic t_fields;
      wr(ba(IDX_OVF_MASK), 32'hFFFF_FFFF);
      rd("mask", ba(IDX_OVF_MASK), 16'h0007);
      wr(ba(IDX_TONE_SETUP), 32'h0000_01B5);
      rd("tone setup", ba(IDX_TONE_SETUP), 16'h01B5);
      tick;
      chk("tone base", {8'h00, 5'h15, 19'h0}, 32'(tone_base_addr_o));
      for (int i = 0; i < 3; i++) begin
         wr(ba(IDX_TONE_SETUP), 32'(i << 5) | (i[0] ? 32'h80 : 32'h100));
         tick;
         chk("tone size", 32'(i), 32'(tone_size_log2_o));
         chk("sdram tone", 32'(i[0]), 32'(sdram_tone_en_o));
         chk("ssram tone", 32'(!i[0]), 32'(ssram_tone_en_o));
      end
      wr(ba(IDX_REC1_REGION), 32'h0000_0BCD);
      rd("region1", ba(IDX_REC1_REGION), 16'h0BCD);
      tick;
      chk("rec1 base", {11'h0, 9'h1CD, 12'h0}, 32'(rec1_base_addr_o));
      chk("rec1 size", 32'h5, 32'(rec1_size_log2_o));
      wr(ba(IDX_REC2_REGION), 32'h0000_0234);
      tick;
      chk("rec2 base", {11'h0, 9'h034, 12'h0}, 32'(rec2_base_addr_o));
      chk("rec2 size", 32'h1, 32'(rec2_size_log2_o));
      wr(ba(IDX_REC1_PROD), 32'h0000_FFFF);
      rd("producer ro", ba(IDX_REC1_PROD), 16'h0000);
   endtask

   task automatic t_flags;
      wr(ba(IDX_OVF_MASK), 32'h0000_0007);
      pulse(1'b0);
      pulse(1'b0);
      tick;
      chk("irq on", 32'h1, 32'(irq_o));
      rd("flags cell", ba(IDX_OVF_FLAGS), 16'h0001);
      rd("flags cleared", ba(IDX_OVF_FLAGS), 16'h0000);
      tick;
      chk("irq off", 32'h0, 32'(irq_o));
      wr(ba(IDX_OVF_MASK), 32'h0000_0003);
      pulse(1'b1);
      tick;
      chk("irq masked", 32'h0, 32'(irq_o));
      rd("flags ring2", ba(IDX_OVF_FLAGS), 16'h0004);
      wr(ba(IDX_OVF_MASK), 32'h0000_0004);
      pulse(1'b1);
      tick;
      chk("irq ring2", 32'h1, 32'(irq_o));
      rd("flags ring2 again", ba(IDX_OVF_FLAGS), 16'h0004);
   endtask

   task automatic t_ring;
      wr(ba(IDX_REC1_REGION), 32'h0);
      @(posedge core_clk_i);
      rec1_store_i <= 1'b1;
      repeat (256) @(posedge core_clk_i);
      rec1_store_i <= 1'b0;
      tick;
      chk("prod ptr", 32'h100, 32'(rec1_prod_ptr_o));
      chk("store idx", 32'h0, 32'(rec1_store_idx_o));
      chk("full", 32'h1, 32'(rec1_full_o));
      chk("empty", 32'h0, 32'(rec1_empty_o));
      rd("flags none", ba(IDX_OVF_FLAGS), 16'h0000);
      @(posedge core_clk_i);
      rec1_store_i <= 1'b1;
      @(posedge core_clk_i);
      rec1_store_i <= 1'b0;
      rd("flags ring1", ba(IDX_OVF_FLAGS), 16'h0002);
      rd("prod held", ba(IDX_REC1_PROD), 16'h0100);
      wr(ba(IDX_REC1_CONS), 32'h0000_0100);
      rd("cons ptr", ba(IDX_REC1_CONS), 16'h0100);
      tick;
      chk("cons out", 32'h100, 32'(rec1_cons_ptr_o));
      chk("empty", 32'h1, 32'(rec1_empty_o));
      chk("full", 32'h0, 32'(rec1_full_o));
   endtask

   task automatic t_err;
      logic [31:0] r;
      logic e;
      apb(1'b0, 16'h2004, 32'h0, r, e);
      chk("unmapped err", 32'h1, 32'(e));
      apb(1'b1, ba(IDX_OVF_MASK) | 16'h0002, 32'h0, r, e);
      chk("misaligned err", 32'h1, 32'(e));
      apb(1'b1, ba(IDX_OVF_MASK) | 16'h8000, 32'h0, r, e);
      chk("high addr err", 32'h1, 32'(e));
      rd("mask kept", ba(IDX_OVF_MASK), 16'h0004);
   endtask

   initial begin
      #100_000;
      fails++;
      print_verdict;
   end

   initial begin
      repeat (8) @(posedge core_clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_fields;
      t_flags;
      t_ring;
      t_err;
      print_verdict;
   end
endmodule
